// ### rtl/wdor_pkg.sv
// Purpose: Shared constants and types for the watchdog overflow reset block
// Assumes: Single 200 MHz clock, on-chip oscillator and counter clock as enable pulses
// Notes: All counts and widths live here
`default_nettype none
package wdor_pkg;
  localparam int unsigned COUNT_W = 8;
  localparam logic [7:0] COUNT_MAX = 8'h00_FF;
  localparam logic [7:0] COUNT_RST = 8'h00_00;
  localparam int unsigned RST_OSC_CYCLES = 512;
  localparam int unsigned PULSE_W = 10;
  localparam logic [9:0] PULSE_LAST = 10'(RST_OSC_CYCLES - 1);
  localparam logic [9:0] PULSE_ZERO = 10'h000_0;
  localparam int unsigned FLAG_BIT = 0;

  typedef enum {WDOR_RUN, WDOR_RESET} wdor_state_t;

  // Software load request
  typedef struct packed {
    logic        load;
    logic [7:0]  value;
  } wdor_load_t;

  // Status seen by software
  typedef struct packed {
    logic [7:0]  count;
    logic        flag;
    logic        reset_active;
  } wdor_status_t;
endpackage
`default_nettype wire

// ### rtl/wdor_pulse.sv
// Purpose: Times the internal reset pulse in on-chip oscillator cycles
// Assumes: osc_tick is a one-cycle enable per oscillator cycle
// Notes: start is taken only while idle
`default_nettype none
module wdor_pulse (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic osc_tick,
  output logic active
);
  logic [9:0] cnt_r;
  logic [9:0] cnt_nxt;
  logic act_r;
  logic act_nxt;

  // ------------------------------------------------------------
  // Pulse counter
  // ------------------------------------------------------------
  always_comb begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (!act_r) begin
      if (start) begin
        act_nxt = 1'b1;
        cnt_nxt = wdor_pkg::PULSE_ZERO;
      end
    end else if (osc_tick) begin
      if (cnt_r == wdor_pkg::PULSE_LAST) begin
        act_nxt = 1'b0; // [RULE4]
      end else begin
        cnt_nxt = cnt_r + 10'h001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= wdor_pkg::PULSE_ZERO;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  assign active = act_r;
endmodule
`default_nettype wire

// ### rtl/wdor_top.sv
// Purpose: Watchdog counter that raises an internal reset pulse on overflow
// Assumes: Counter clock and oscillator arrive as one-cycle enables on CLK
// Notes: Status flag survives the internal reset it causes; only RST_N or FLAG_CLEAR clears it
`default_nettype none
// Function
// RULE1 - Set the reset flag, bit 0 of status, when overflow makes a reset
// RULE2 - The watchdog's own internal reset never clears the reset flag
// RULE3 - A counter pulse while count holds its maximum is an overflow
// RULE4 - Hold internal reset for exactly 512 oscillator cycles, then release
// RULE5 - Count up on each counter pulse; software may load a new count
module wdor_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CNT_TICK,
  input wire logic OSC_TICK,
  input wire wdor_pkg::wdor_load_t LOAD,
  input wire logic FLAG_CLEAR,
  output logic INT_RESET,
  output logic [7:0] CONTROL_STATUS_ONE,
  output wdor_pkg::wdor_status_t STATUS
);
  // ------------------------------------------------------------
  // Internal state
  // ------------------------------------------------------------
  // Count
  logic [7:0] watchdog_count_r;
  logic [7:0] watchdog_count_nxt;

  // Run state and the one-cycle overflow strobe
  logic ovf_r;
  logic ovf_nxt;
  wdor_pkg::wdor_state_t state_r;
  wdor_pkg::wdor_state_t state_nxt;

  // Flag
  logic watchdog_reset_flag_r;
  logic watchdog_reset_flag_nxt;

  // Output registers
  logic int_reset_r;
  logic int_reset_nxt;
  logic [7:0] csr_r;
  logic [7:0] csr_nxt;
  wdor_pkg::wdor_status_t status_r;
  wdor_pkg::wdor_status_t status_nxt;

  // Requests as taken by the counter
  logic running;
  logic load_taken;
  logic tick_taken;
  logic overflow_now;
  logic pulse_active;

  // ------------------------------------------------------------
  // Request decoding
  // ------------------------------------------------------------
  function automatic logic is_max(input logic [7:0] v);
    is_max = (v == wdor_pkg::COUNT_MAX);
  endfunction

  // Load and count requests are refused while the internal reset runs
  function automatic logic is_running(input wdor_pkg::wdor_state_t s);
    is_running = (s == wdor_pkg::WDOR_RUN);
  endfunction

  always_comb begin
    running = is_running(state_r);
    load_taken = running && LOAD.load;
    tick_taken = running && !LOAD.load && CNT_TICK;
    overflow_now = tick_taken && is_max(watchdog_count_r); // [RULE3]
  end

  // ------------------------------------------------------------
  // Watchdog count
  // ------------------------------------------------------------
  always_comb begin
    watchdog_count_nxt = watchdog_count_r;
    if (!running) begin
      // Held at zero for the whole internal reset
      watchdog_count_nxt = wdor_pkg::COUNT_RST;
    end else if (load_taken) begin
      watchdog_count_nxt = LOAD.value; // [RULE5]
    end else if (overflow_now) begin
      watchdog_count_nxt = wdor_pkg::COUNT_RST;
    end else if (tick_taken) begin
      watchdog_count_nxt = watchdog_count_r + 8'h01; // [RULE5]
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      watchdog_count_r <= wdor_pkg::COUNT_RST;
    end else begin
      watchdog_count_r <= watchdog_count_nxt;
    end
  end

  // ------------------------------------------------------------
  // Overflow and run state
  // ------------------------------------------------------------
  always_comb begin
    ovf_nxt = 1'b0;
    state_nxt = state_r;
    case (state_r)
      wdor_pkg::WDOR_RUN: begin
        if (overflow_now) begin
          ovf_nxt = 1'b1; // [RULE3]
          state_nxt = wdor_pkg::WDOR_RESET;
        end
      end
      wdor_pkg::WDOR_RESET: begin
        // Stay until the timer has started and then finished
        if (!pulse_active && !ovf_r) begin
          state_nxt = wdor_pkg::WDOR_RUN;
        end
      end
      default: begin
        state_nxt = wdor_pkg::WDOR_RUN;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ovf_r <= 1'b0;
      state_r <= wdor_pkg::WDOR_RUN;
    end else begin
      ovf_r <= ovf_nxt;
      state_r <= state_nxt;
    end
  end

  // ------------------------------------------------------------
  // Watchdog reset flag
  // ------------------------------------------------------------
  always_comb begin
    watchdog_reset_flag_nxt = watchdog_reset_flag_r;
    if (FLAG_CLEAR) begin
      watchdog_reset_flag_nxt = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (overflow_now) begin
      watchdog_reset_flag_nxt = 1'b1; // [RULE1]
    end
  end

  // Only RST_N resets the flag; the internal reset is not wired here
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      watchdog_reset_flag_r <= 1'b0;
    end else begin
      watchdog_reset_flag_r <= watchdog_reset_flag_nxt; // [RULE2]
    end
  end

  // ------------------------------------------------------------
  // Reset pulse timer
  // ------------------------------------------------------------
  wdor_pulse u_pulse (
    .clk(CLK),
    .rst_n(RST_N),
    .start(ovf_r), // [RULE3]
    .osc_tick(OSC_TICK),
    .active(pulse_active)
  );

  // ------------------------------------------------------------
  // Internal reset output
  // ------------------------------------------------------------
  always_comb begin
    int_reset_nxt = pulse_active; // [RULE4]
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      int_reset_r <= 1'b0;
    end else begin
      int_reset_r <= int_reset_nxt;
    end
  end

  // ------------------------------------------------------------
  // Control and status image
  // ------------------------------------------------------------
  always_comb begin
    csr_nxt = 8'h00;
    csr_nxt[wdor_pkg::FLAG_BIT] = watchdog_reset_flag_r; // [RULE1]
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      csr_r <= 8'h00;
    end else begin
      csr_r <= csr_nxt;
    end
  end

  // ------------------------------------------------------------
  // Status word
  // ------------------------------------------------------------
  always_comb begin
    status_nxt.count = watchdog_count_r;
    status_nxt.flag = watchdog_reset_flag_r;
    status_nxt.reset_active = pulse_active;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // ------------------------------------------------------------
  // Output ports
  // ------------------------------------------------------------
  assign INT_RESET = int_reset_r;
  assign CONTROL_STATUS_ONE = csr_r;
  assign STATUS = status_r;
endmodule
`default_nettype wire

// ### bench/wdor_sva.sv
// Purpose: Port checks
// Assumes: Sync reset
// Notes: Bound below
`default_nettype none
module wdor_sva (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CNT_TICK,
  input wire logic OSC_TICK,
  input wire wdor_pkg::wdor_load_t LOAD,
  input wire logic FLAG_CLEAR,
  input wire logic INT_RESET,
  input wire logic [7:0] CONTROL_STATUS_ONE,
  input wire wdor_pkg::wdor_status_t STATUS
);
  logic [9:0] n_r;
  logic osc_d_r;
  logic tk_d_r;
  logic ovd_d_r;
  logic busy;
  logic run;
  logic tk;
  logic ovd;
  // STATUS.count lags the count by one cycle, so overflow is seen one cycle late
  assign ovd = tk_d_r && STATUS.count == 8'hFF;
  assign busy = ovd || ovd_d_r || INT_RESET;
  assign run = !busy;
  assign tk = run && !LOAD.load && CNT_TICK;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      osc_d_r <= 1'b0;
      tk_d_r <= 1'b0;
      ovd_d_r <= 1'b0;
      n_r <= 10'h000;
    end else begin
      osc_d_r <= OSC_TICK;
      tk_d_r <= tk;
      ovd_d_r <= ovd;
      n_r <= INT_RESET ? n_r + 10'(osc_d_r) : 10'h000;
    end
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_ovf_fire: assert property (ovd |-> ##2 INT_RESET && STATUS.reset_active)
    else $error("no reset");
  chk_flag_set: assert property (ovd |=> STATUS.flag && CONTROL_STATUS_ONE == 8'h01)
    else $error("flag");
  chk_flag_keep: assert property (INT_RESET && STATUS.flag && !$past(FLAG_CLEAR) |=> STATUS.flag)
    else $error("flag lost");
  chk_pulse_len: assert property ($fell(INT_RESET) |-> n_r == 10'h200)
    else $error("length");
  chk_cnt_inc: assert property (tk_d_r && STATUS.count != 8'hFF |=> STATUS.count == $past(STATUS.count) + 8'h01)
    else $error("count");
  chk_cnt_load: assert property (run && LOAD.load |=> ##1 STATUS.count == $past(LOAD.value, 2))
    else $error("load");
  chk_cnt_hold: assert property (busy |-> ##2 STATUS.count == 8'h00)
    else $error("count not held");
endmodule
bind wdor_top wdor_sva chk (.CLK(CLK), .RST_N(RST_N), .CNT_TICK(CNT_TICK),
  .OSC_TICK(OSC_TICK), .LOAD(LOAD), .FLAG_CLEAR(FLAG_CLEAR), .INT_RESET(INT_RESET),
  .CONTROL_STATUS_ONE(CONTROL_STATUS_ONE), .STATUS(STATUS));
`default_nettype wire

// ### bench/testbench.sv
// Purpose: Random and directed test
// Assumes: Inputs change on falling edge
// Notes: Oscillator tick every fourth cycle
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 0, RST_N = 0, CT = 0, OT = 0, FC = 0, IR;
  wdor_pkg::wdor_load_t LD = '0;
  wdor_pkg::wdor_status_t st;
  logic [7:0] csr, v, e;
  logic [31:0] sd = 32'h0000_9310;
  logic [1:0] ph = 0;
  int n_fail = 0, n_tests = 0, cyc = 0, n;
  wdor_top dut (.CLK(CLK), .RST_N(RST_N), .CNT_TICK(CT), .OSC_TICK(OT), .LOAD(LD),
    .FLAG_CLEAR(FC), .INT_RESET(IR), .CONTROL_STATUS_ONE(csr), .STATUS(st));
  always #2.5 CLK = ~CLK;
  always @(negedge CLK) begin
    ph <= ph + 2'h1;
    OT <= ph == 2'h0;
  end
  function automatic logic [31:0] rnd();
    sd ^= sd << 13;
    sd ^= sd >> 17;
    sd ^= sd << 5;
    return sd;
  endfunction
  task automatic chk(input logic [9:0] g, input logic [9:0] x);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask
  task conclude();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 9000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(negedge CLK);
    RST_N = 1;
    @(negedge CLK);
    chk(csr, 0);
    for (int t = 0; t < 6; t++) begin
      v = 8'(rnd()) & 8'h7F;
      e = v;
      LD = {1'b1, v};
      CT = 1;
      @(negedge CLK);
      LD = '0;
      repeat (20) begin
        CT = 1'(rnd());
        e = e + 8'(CT);
        @(negedge CLK);
      end
      CT = 0;
      @(negedge CLK);
      chk(st.count, e);
      $display("count test %0d done", t);
    end
    for (int t = 0; t < 2; t++) begin
      LD = {1'b1, 8'hFF};
      @(negedge CLK);
      LD = '0;
      while (ph != 2'h1) @(negedge CLK);
      CT = 1;
      FC = 1'(t);
      @(negedge CLK);
      CT = 0;
      FC = 0;
      @(negedge CLK);
      chk(st.flag, 1);
      chk(csr, 1);
      chk(st.count, 0);
      @(negedge CLK);
      chk(IR, 1);
      chk(st.reset_active, 1);
      n = 0;
      for (int i = 0; i < 2100; i++) begin
        CT = i < 1000 ? 1'(rnd()) : 1'b0;
        LD = {i < 1000 ? 1'(rnd()) : 1'b0, 8'(rnd())};
        @(negedge CLK);
        if (IR && OT) n++;
      end
      chk(10'(n), 512);
      chk(IR, 0);
      chk(st.reset_active, 0);
      chk(st.count, 0);
      chk(csr, 1);
      FC = 1;
      @(negedge CLK);
      FC = 0;
      @(negedge CLK);
      chk(csr, 0);
      $display("overflow test %0d done", t);
    end
    conclude();
  end
endmodule
`default_nettype wire
